/* File: hw/ddrl_pkg.sv */
// shared constants, command codes and carrier types for the local interface
package ddrl_pkg;

  // clock and timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int TREFI_NS      = 7800;
  localparam int TREFI_CYC     = TREFI_NS / CLK_PERIOD_NS; // longest: floor
  localparam int REFI_W        = 16;

  // local address layout: {row, bank, column}
  localparam int ADDR_W   = 24;
  localparam int COL_W    = 9;
  localparam int BA_W     = 2;
  localparam int ROW_W    = 13;
  localparam int COL_POS  = 0;
  localparam int BA_POS   = COL_POS + COL_W;
  localparam int ROW_POS  = BA_POS + BA_W;
  localparam int MEM_A_W  = 13;

  // request buffer depth
  localparam int REQ_DEPTH = 4;

  // correction port register map, word index
  localparam int          ECC_ADDR_W   = 2;
  localparam int          ECC_DATA_W   = 32;
  localparam logic [1:0]  ECC_REG_CTRL = 2'h0;
  localparam logic [1:0]  ECC_REG_SBE  = 2'h1;
  localparam logic [1:0]  ECC_REG_DBE  = 2'h2;
  localparam logic [1:0]  ECC_REG_ADDR = 2'h3;
  localparam int          CTRL_IEN_POS = 0;
  localparam int          CTRL_DBE_POS = 8;
  localparam logic [ECC_DATA_W-1:0] ECC_CTRL_RST = 32'h0000_0000;

  // memory command bundle, all active low
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } ddrl_cmd_t;

  localparam ddrl_cmd_t CMD_NOP = 4'h7;
  localparam ddrl_cmd_t CMD_ACT = 4'h3;
  localparam ddrl_cmd_t CMD_RD  = 4'h5;
  localparam ddrl_cmd_t CMD_WR  = 4'h4;
  localparam ddrl_cmd_t CMD_REF = 4'h1;
  localparam ddrl_cmd_t CMD_DES = 4'hf;

  // one buffered local request
  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
  } ddrl_req_t;

  // command engine states
  typedef enum logic [3:0] {
    ST_IDLE, ST_ACT, ST_WCMD, ST_WBEAT, ST_RCMD, ST_RWAIT, ST_RBEAT,
    ST_RDONE, ST_REF, ST_PD, ST_SR
  } ddrl_state_t;

endpackage : ddrl_pkg

/* File: hw/ddrl_local_if.sv */
// request buffer and local-interface command engine of the sdram controller
`timescale 1ns/1ns

// small first-in first-out buffer in flip-flops
module ddrl_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 4
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int PW = $clog2(DEPTH);
  logic [W-1:0]  mem_q [DEPTH];
  logic [PW-1:0] wp_q;
  logic [PW-1:0] rp_q;
  logic [PW:0]   cnt_q;
  logic          push;
  logic          pop;

  // handshakes from the fill count
  assign in_ready_o  = (cnt_q != (PW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  assign out_data_o  = mem_q[rp_q];

  // storage writes
  always_ff @(posedge clk_i)
  begin
    if (push)
      mem_q[wp_q] <= in_data_i;
  end

  // pointers and count
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
        wp_q <= (wp_q == PW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
      if (pop)
        rp_q <= (rp_q == PW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
      cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule : ddrl_fifo

// local interface, command engine and correction port
module ddrl_local_if #(
  parameter int MEM_W     = 16,
  parameter bit HALF_RATE = 1'b0,
  parameter bit DDR2      = 1'b1,
  parameter bit ECC_EN    = 1'b1,
  parameter int CAS_LAT   = 3,
  parameter int REFI_CYC  = ddrl_pkg::TREFI_CYC,
  parameter int RATE_MUL  = HALF_RATE ? 4 : 2,
  parameter int LOC_W     = MEM_W * RATE_MUL,
  parameter int CHK_W     = $clog2(MEM_W + 1) + 1
) (
  input  wire logic                       clk_i,
  input  wire logic                       rst_n_i,
  input  wire logic                       pll_locked_i,
  input  wire logic                       seq_user_mode_rdy_i,
  input  wire logic                       resync_ok_i,
  input  wire logic                       postamble_ok_i,
  output logic                            reset_request_n_o,
  output logic                            user_rst_n_o,
  output logic                            init_done_o,
  output logic                            resync_success_o,
  output logic                            postamble_success_o,
  input  wire logic                       read_req_i,
  input  wire logic                       write_req_i,
  input  wire logic [ddrl_pkg::ADDR_W-1:0] addr_i,
  output logic                            ready_o,
  output logic                            wdata_req_o,
  input  wire logic [LOC_W-1:0]           wdata_i,
  input  wire logic [LOC_W/8-1:0]         be_i,
  output logic [LOC_W-1:0]                rdata_o,
  output logic                            rdata_valid_o,
  output logic                            rdata_error_o,
  output logic                            refresh_ack_o,
  input  wire logic                       powerdn_req_i,
  output logic                            powerdn_ack_o,
  input  wire logic                       self_rfsh_req_i,
  output logic                            self_rfsh_ack_o,
  output ddrl_pkg::ddrl_cmd_t             mem_cmd_o,
  output logic [ddrl_pkg::MEM_A_W-1:0]    mem_a_o,
  output logic [ddrl_pkg::BA_W-1:0]       mem_ba_o,
  output logic                            mem_cke_o,
  output logic                            mem_odt_o,
  output logic [MEM_W-1:0]                mem_dq_o,
  output logic                            mem_dq_oe_o,
  input  wire logic [MEM_W-1:0]           mem_dq_i,
  output logic [CHK_W-1:0]                mem_chk_o,
  input  wire logic [CHK_W-1:0]           mem_chk_i,
  output logic [MEM_W/8-1:0]              memory_byte_mask_o,
  input  wire logic                       ecc_read_req_i,
  input  wire logic                       ecc_write_req_i,
  input  wire logic [ddrl_pkg::ECC_ADDR_W-1:0] ecc_addr_i,
  input  wire logic [ddrl_pkg::ECC_DATA_W/8-1:0] correction_port_byte_en_i,
  input  wire logic [ddrl_pkg::ECC_DATA_W-1:0] ecc_wdata_i,
  output logic [ddrl_pkg::ECC_DATA_W-1:0] ecc_rdata_o,
  output logic                            ecc_interrupt_o
);
  import ddrl_pkg::*;

  localparam int SW  = CHK_W - 1;
  localparam int BMW = MEM_W / 8;
  localparam int BW  = $clog2(RATE_MUL);

  ddrl_state_t          state_q;
  ddrl_req_t            req_in;
  ddrl_req_t            req_q;
  logic                 req_valid;
  logic                 pop;
  logic [2:0]           lock_q;
  logic [1:0]           urst_q;
  logic [REFI_W-1:0]    refi_q;
  logic                 ref_due_q;
  logic [BW:0]          cnt_q;
  logic [LOC_W-1:0]     wbuf_q;
  logic [LOC_W/8-1:0]   bebuf_q;
  logic [LOC_W-1:0]     rbuf_q;
  logic                 rerr_q;
  logic [MEM_W-1:0]     beat_fix;
  logic                 beat_sbe;
  logic                 beat_dbe;
  logic [MEM_W-1:0]     wbeat;
  logic [ECC_DATA_W-1:0] ctrl_q;
  logic [ECC_DATA_W-1:0] sbe_q;
  logic [ECC_DATA_W-1:0] dbe_q;
  logic [ECC_DATA_W-1:0] eaddr_q;

  // hamming syndrome of one memory beat
  function automatic logic [SW-1:0] syn_f(input logic [MEM_W-1:0] d);
    logic [SW-1:0] s;
    s = '0;
    for (int i = 0; i < MEM_W; i++)
      if (d[i])
        s = s ^ SW'(i + 1);
    return s;
  endfunction : syn_f

  // reset request tracks the clock lock, user reset synchronised
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      lock_q <= '0;
      urst_q <= '0;
    end
    else
    begin
      lock_q <= {lock_q[1:0], pll_locked_i};
      urst_q <= {urst_q[0], 1'b1};
    end
  end
  assign reset_request_n_o = lock_q[2];
  assign user_rst_n_o      = urst_q[1];

  // status flags: ready level and separate calibration results
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      init_done_o         <= 1'b0;
      resync_success_o    <= 1'b0;
      postamble_success_o <= 1'b0;
    end
    else
    begin
      init_done_o         <= seq_user_mode_rdy_i;
      resync_success_o    <= resync_ok_i;
      postamble_success_o <= postamble_ok_i;
    end
  end

  // request buffer; requests held here until init done
  assign req_in = '{write: write_req_i, addr: addr_i};
  assign pop    = (state_q == ST_WCMD)
                  || (state_q == ST_RDONE);   // head kept until used
  ddrl_fifo #(
    .W     ($bits(ddrl_req_t)),
    .DEPTH (REQ_DEPTH)
  ) u_req_fifo (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (read_req_i || write_req_i),
    .in_ready_o  (ready_o),
    .in_data_i   (req_in),
    .out_valid_o (req_valid),
    .out_ready_i (pop),
    .out_data_o  (req_q)
  );

  // refresh interval timer
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      refi_q    <= '0;
      ref_due_q <= 1'b0;
    end
    else if (state_q == ST_REF || state_q == ST_SR)
    begin
      refi_q    <= '0;
      ref_due_q <= 1'b0;
    end
    else if (refi_q == REFI_W'(REFI_CYC - 1))
    begin
      refi_q    <= '0;
      ref_due_q <= init_done_o;
    end
    else
      refi_q <= refi_q + 1'b1;
  end

  // command engine: state, memory command and address
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_q   <= ST_IDLE;
      mem_cmd_o <= CMD_DES;
      mem_a_o   <= '0;
      mem_ba_o  <= '0;
      mem_cke_o <= 1'b0;
      cnt_q     <= '0;
    end
    else
    begin
      mem_cmd_o <= CMD_NOP;
      mem_cke_o <= 1'b1;
      case (state_q)
        ST_IDLE:
        begin
          if (!init_done_o)
            mem_cmd_o <= CMD_DES;
          else if (ref_due_q)
          begin
            mem_cmd_o <= CMD_REF;
            state_q   <= ST_REF;
          end
          else if (self_rfsh_req_i)
          begin
            mem_cmd_o <= CMD_REF;               // self refresh entry
            mem_cke_o <= 1'b0;
            state_q   <= ST_SR;
          end
          else if (powerdn_req_i)
          begin
            mem_cke_o <= 1'b0;
            state_q   <= ST_PD;
          end
          else if (req_valid)
          begin
            mem_cmd_o <= CMD_ACT;
            mem_a_o   <= MEM_A_W'(req_q.addr[ROW_POS +: ROW_W]);
            mem_ba_o  <= req_q.addr[BA_POS +: BA_W];
            state_q   <= req_q.write ? ST_WCMD : ST_RCMD;
          end
        end
        ST_WCMD:
        begin
          mem_cmd_o <= CMD_WR;
          mem_a_o   <= MEM_A_W'(req_q.addr[COL_POS +: COL_W]);
          cnt_q     <= '0;
          state_q   <= ST_WBEAT;
        end
        ST_WBEAT:
        begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == (BW+1)'(RATE_MUL - 1))
            state_q <= ST_IDLE;
        end
        ST_RCMD:
        begin
          mem_cmd_o <= CMD_RD;
          mem_a_o   <= MEM_A_W'(req_q.addr[COL_POS +: COL_W]);
          cnt_q     <= '0;
          state_q   <= ST_RWAIT;
        end
        ST_RWAIT:
        begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == (BW+1)'(CAS_LAT - 1))
          begin
            cnt_q   <= '0;
            state_q <= ST_RBEAT;
          end
        end
        ST_RBEAT:
        begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == (BW+1)'(RATE_MUL - 1))
            state_q <= ST_RDONE;
        end
        ST_RDONE:
          state_q <= ST_IDLE;
        ST_REF:
          state_q <= ST_IDLE;
        ST_PD:
        begin
          mem_cke_o <= 1'b0;
          if (!powerdn_req_i || ref_due_q)
          begin
            mem_cke_o <= 1'b1;
            state_q   <= ST_IDLE;
          end
        end
        ST_SR:
        begin
          mem_cke_o <= 1'b0;
          if (!self_rfsh_req_i)
          begin
            mem_cke_o <= 1'b1;
            state_q   <= ST_IDLE;
          end
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // acknowledges and write data request decoded from the state
  assign wdata_req_o     = (state_q == ST_WCMD);
  assign powerdn_ack_o   = (state_q == ST_PD);
  assign self_rfsh_ack_o = (state_q == ST_SR);
  assign refresh_ack_o   = (state_q == ST_REF);

  // write data captured one edge after the request
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wbuf_q  <= '0;
      bebuf_q <= '0;
    end
    else if (state_q == ST_WCMD)
    begin
      wbuf_q  <= wdata_i;
      bebuf_q <= be_i;
    end
  end

  // memory write drive, one beat per cycle
  assign wbeat = wbuf_q[cnt_q[BW-1:0]*MEM_W +: MEM_W];
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      mem_dq_o           <= '0;
      mem_dq_oe_o        <= 1'b0;
      mem_chk_o          <= '0;
      memory_byte_mask_o <= '0;
    end
    else
    begin
      mem_dq_oe_o <= (state_q == ST_WBEAT);
      mem_dq_o    <= wbeat;
      mem_chk_o   <= ECC_EN ? {^wbeat, syn_f(wbeat)} : '0;
      memory_byte_mask_o <= (state_q == ST_WBEAT)
        ? ~bebuf_q[cnt_q[BW-1:0]*BMW +: BMW] : '0;
    end
  end

  // termination exists only for ddr2
  generate
    if (DDR2)
    begin : g_odt
      always_ff @(posedge clk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
          mem_odt_o <= 1'b0;
        else
          mem_odt_o <= (state_q == ST_WBEAT);
      end
    end
    else
    begin : g_no_odt
      assign mem_odt_o = 1'b0;
    end
  endgenerate

  // per-beat check: single errors fixed, double errors left as read
  always_comb
  begin
    logic [SW-1:0] s;
    logic          pm;
    s        = syn_f(mem_dq_i) ^ mem_chk_i[SW-1:0];
    pm       = (^mem_dq_i) ^ mem_chk_i[SW];
    beat_fix = mem_dq_i;
    beat_sbe = ECC_EN && (s != '0) && pm;
    beat_dbe = ECC_EN && (s != '0) && !pm;
    if (beat_sbe && (int'(s) <= MEM_W))
      beat_fix[int'(s) - 1] = ~mem_dq_i[int'(s) - 1];
  end

  // read beats assembled into one local word
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rbuf_q <= '0;
      rerr_q <= 1'b0;
    end
    else if (state_q == ST_RCMD)
      rerr_q <= 1'b0;
    else if (state_q == ST_RBEAT)
    begin
      rbuf_q[cnt_q[BW-1:0]*MEM_W +: MEM_W] <= beat_fix;
      rerr_q <= rerr_q | beat_dbe;
    end
  end

  // local read return, valid only with presented data
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rdata_o       <= '0;
      rdata_valid_o <= 1'b0;
      rdata_error_o <= 1'b0;
    end
    else
    begin
      rdata_valid_o <= (state_q == ST_RDONE);
      rdata_error_o <= ECC_EN && (state_q == ST_RDONE) && rerr_q;
      if (state_q == ST_RDONE)
        rdata_o <= rbuf_q;
    end
  end

  // correction port registers and error counters
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ctrl_q  <= ECC_CTRL_RST;
      sbe_q   <= '0;
      dbe_q   <= '0;
      eaddr_q <= '0;
    end
    else
    begin
      if (ecc_write_req_i)
      begin
        for (int b = 0; b < ECC_DATA_W/8; b++)
          if (correction_port_byte_en_i[b] && ecc_addr_i == ECC_REG_CTRL)
            ctrl_q[b*8 +: 8] <= ecc_wdata_i[b*8 +: 8];
        if (ecc_addr_i == ECC_REG_SBE)
          sbe_q <= '0;
        if (ecc_addr_i == ECC_REG_DBE)
          dbe_q <= '0;
      end
      if (state_q == ST_RBEAT && beat_sbe)
        sbe_q <= sbe_q + 1'b1;
      if (state_q == ST_RBEAT && beat_dbe)
      begin
        dbe_q   <= dbe_q + 1'b1;
        eaddr_q <= ECC_DATA_W'(req_q.addr);
        ctrl_q[CTRL_DBE_POS] <= 1'b1;                     // set wins
      end
    end
  end

  // correction port read return and interrupt
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      ecc_rdata_o <= '0;
    else if (ecc_read_req_i)
    begin
      case (ecc_addr_i)
        ECC_REG_CTRL: ecc_rdata_o <= ctrl_q;
        ECC_REG_SBE:  ecc_rdata_o <= sbe_q;
        ECC_REG_DBE:  ecc_rdata_o <= dbe_q;
        ECC_REG_ADDR: ecc_rdata_o <= eaddr_q;
        default:      ecc_rdata_o <= '0;
      endcase
    end
  end
  assign ecc_interrupt_o = ctrl_q[CTRL_IEN_POS] && ctrl_q[CTRL_DBE_POS];

endmodule : ddrl_local_if

/* File: tb/ddrl_local_if_checker.sv */
// concurrent checks on the local interface ports
`timescale 1ns/1ns
module ddrl_local_if_checker #(
  parameter bit DDR2   = 1'b1,
  parameter bit ECC_EN = 1'b1,
  parameter int MEM_W  = 16
) (
  input wire logic                clk_i,
  input wire logic                rst_n_i,
  input wire logic                pll_locked_i,
  input wire logic                reset_request_n_o,
  input wire logic                seq_user_mode_rdy_i,
  input wire logic                init_done_o,
  input wire logic                read_req_i,
  input wire logic                write_req_i,
  input wire logic                ready_o,
  input wire logic                rdata_valid_o,
  input wire logic                rdata_error_o,
  input wire logic                refresh_ack_o,
  input wire logic                powerdn_req_i,
  input wire logic                powerdn_ack_o,
  input wire logic                self_rfsh_req_i,
  input wire logic                self_rfsh_ack_o,
  input wire ddrl_pkg::ddrl_cmd_t mem_cmd_o,
  input wire logic                mem_odt_o,
  input wire logic                mem_dq_oe_o,
  input wire logic [MEM_W/8-1:0]  memory_byte_mask_o,
  input wire logic                wdata_req_o
);
  import ddrl_pkg::*;
  logic [2:0] early_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // requests taken while the engine must still hold them back
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      early_q <= 3'h0;
    else if (!init_done_o && (read_req_i || write_req_i) && ready_o)
      early_q <= early_q + 3'h1;
  end

  // a refresh command stands now or stood one cycle ago
  sequence s_ref_seen;
    mem_cmd_o == CMD_REF || $past(mem_cmd_o) == CMD_REF;
  endsequence

  a_req_unlocked: assert property (!pll_locked_i [*4] |-> !reset_request_n_o)
    else $error("reset request high while unlocked");
  a_done_follow: assert property (seq_user_mode_rdy_i |=> init_done_o)
    else $error("init done missing after sequencer ready");
  a_hold_early: assert property (!init_done_o [*2] |->
    (mem_cmd_o == CMD_NOP || mem_cmd_o == CMD_DES))
    else $error("command issued before init done");
  a_err_valid: assert property (rdata_error_o |-> rdata_valid_o && ECC_EN)
    else $error("read error without valid");
  a_valid_pulse: assert property (rdata_valid_o |=> !rdata_valid_o)
    else $error("read valid longer than one word");
  a_ready_four: assert property (!init_done_o |->
    ready_o == (early_q < 3'h4))
    else $error("ready does not track four buffered requests");
  a_ref_once: assert property (refresh_ack_o |-> s_ref_seen ##1 !refresh_ack_o)
    else $error("refresh acknowledge not a single pulse at refresh");
  a_pd_drop: assert property (!powerdn_req_i |=> !powerdn_ack_o)
    else $error("power-down ack stays after request dropped");
  a_pd_cause: assert property ($rose(powerdn_ack_o) |-> $past(powerdn_req_i))
    else $error("power-down ack without request");
  a_sr_drop: assert property (!self_rfsh_req_i |=> !self_rfsh_ack_o)
    else $error("self-refresh ack stays after request dropped");
  a_odt_gate: assert property (mem_odt_o |-> DDR2 &&
    (mem_dq_oe_o || $past(mem_dq_oe_o)))
    else $error("termination outside ddr2 write beats");
  a_mask_idle: assert property (!mem_dq_oe_o |-> memory_byte_mask_o == '0)
    else $error("byte mask set outside write beats");
  a_wreq_pulse: assert property (wdata_req_o |=> !wdata_req_o)
    else $error("write data request longer than one cycle");

endmodule : ddrl_local_if_checker

bind ddrl_local_if ddrl_local_if_checker #(
  .DDR2(DDR2), .ECC_EN(ECC_EN), .MEM_W(MEM_W)
) chk_u (
  .clk_i, .rst_n_i, .pll_locked_i, .reset_request_n_o,
  .seq_user_mode_rdy_i, .init_done_o, .read_req_i, .write_req_i, .ready_o,
  .rdata_valid_o, .rdata_error_o, .refresh_ack_o, .powerdn_req_i,
  .powerdn_ack_o, .self_rfsh_req_i, .self_rfsh_ack_o, .mem_cmd_o,
  .mem_odt_o, .mem_dq_oe_o, .memory_byte_mask_o, .wdata_req_o
);

/* File: tb/ddrl_mem_model.sv */
// memory device model on the sdram pins, with read bit-flip injection
`timescale 1ns/1ns
module ddrl_mem_model #(
  parameter int MEM_W   = 16,
  parameter int CHK_W   = 6,
  parameter int CAS_LAT = 3,
  parameter int BEATS   = 2
) (
  input  wire logic                         clk_i,
  input  wire logic                         rst_n_i,
  input  wire ddrl_pkg::ddrl_cmd_t          cmd_i,
  input  wire logic [ddrl_pkg::MEM_A_W-1:0] a_i,
  input  wire logic [MEM_W+CHK_W-1:0]       wr_i,
  input  wire logic                         oe_i,
  input  wire logic [1:0]                   flip_i,
  output logic [MEM_W+CHK_W-1:0]            rd_o
);
  import ddrl_pkg::*;
  localparam int DW = MEM_W + CHK_W;
  logic [DW-1:0] mem_q [16*BEATS];
  logic [DW-1:0] junk_q;
  int            wi_q;
  int            rc_q;
  int            rn_q;

  // beats after a write command land in order at that column, checks too
  always_ff @(posedge clk_i)
  begin
    if (cmd_i == CMD_WR)
      wi_q <= int'(a_i[3:0]) * BEATS;
    else if (oe_i)
    begin
      mem_q[wi_q] <= wr_i;
      wi_q <= wi_q + 1;
    end
  end

  // cycles since the last read command, filler moves every cycle
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rn_q <= 99;
      junk_q <= '0;
    end
    else
    begin
      junk_q <= junk_q + 1'b1;
      rn_q <= (cmd_i == CMD_RD) ? 1 : ((rn_q < 99) ? rn_q + 1 : rn_q);
      if (cmd_i == CMD_RD)
        rc_q <= int'(a_i[3:0]) * BEATS;
    end
  end

  // stored beats only in the cas window, never a stale value outside it
  always_comb
  begin
    if (rn_q >= CAS_LAT && rn_q < CAS_LAT + BEATS)
      rd_o = mem_q[rc_q + rn_q - CAS_LAT]
             ^ DW'((rn_q == CAS_LAT) ? flip_i : 2'h0);
    else
      rd_o = ~junk_q;
  end

endmodule : ddrl_mem_model

/* File: tb/tb_top.sv */
// self-checking bench for the local interface with a memory model
`timescale 1ns/1ns
module tb_top;
  import ddrl_pkg::*;
  localparam int LW  = 32;
  localparam int CW  = 6;
  localparam int RFC = 40;
  logic clk_i = 1'b0;
  logic rst_n_i, pll_locked_i, seq_user_mode_rdy_i, resync_ok_i;
  logic postamble_ok_i, read_req_i, write_req_i, powerdn_req_i;
  logic self_rfsh_req_i, ecc_read_req_i, ecc_write_req_i;
  logic reset_request_n_o, user_rst_n_o, init_done_o, resync_success_o;
  logic postamble_success_o, ready_o, wdata_req_o, rdata_valid_o;
  logic rdata_error_o, refresh_ack_o, powerdn_ack_o, self_rfsh_ack_o;
  logic mem_odt_o, mem_dq_oe_o, ecc_interrupt_o;
  logic [ADDR_W-1:0]  addr_i;
  logic [LW-1:0]      wdata_i, rdata_o;
  logic [3:0]         be_i, correction_port_byte_en_i;
  logic [1:0]         ecc_addr_i, memory_byte_mask_o, flip;
  logic [31:0]        ecc_wdata_i, ecc_rdata_o;
  logic [MEM_A_W-1:0] mem_a_o;
  logic [15:0]        mem_dq_o, mem_dq_i;
  logic [CW-1:0]      mem_chk_o, mem_chk_i;
  ddrl_cmd_t          mem_cmd_o;
  logic [LW+3:0]      wq[$];
  logic [1:0]         mq[$];
  int fail_count = 0;
  int comparisons = 0;
  int cyc = 0;
  int refs = 0;
  int i;

  always #20 clk_i = ~clk_i;

  ddrl_local_if #(.REFI_CYC(RFC)) dut_u (
    .clk_i, .rst_n_i, .pll_locked_i, .seq_user_mode_rdy_i, .resync_ok_i,
    .postamble_ok_i, .reset_request_n_o, .user_rst_n_o, .init_done_o,
    .resync_success_o, .postamble_success_o, .read_req_i, .write_req_i,
    .addr_i, .ready_o, .wdata_req_o, .wdata_i, .be_i, .rdata_o,
    .rdata_valid_o, .rdata_error_o, .refresh_ack_o, .powerdn_req_i,
    .powerdn_ack_o, .self_rfsh_req_i, .self_rfsh_ack_o, .mem_cmd_o,
    .mem_a_o, .mem_ba_o(), .mem_cke_o(), .mem_odt_o, .mem_dq_o,
    .mem_dq_oe_o, .mem_dq_i, .mem_chk_o, .mem_chk_i, .memory_byte_mask_o,
    .ecc_read_req_i, .ecc_write_req_i, .ecc_addr_i, .ecc_wdata_i,
    .correction_port_byte_en_i, .ecc_rdata_o, .ecc_interrupt_o
  );

  ddrl_mem_model #(.CHK_W(CW)) mem_u (
    .clk_i, .rst_n_i, .cmd_i(mem_cmd_o), .a_i(mem_a_o),
    .wr_i({mem_chk_o, mem_dq_o}), .oe_i(mem_dq_oe_o), .flip_i(flip),
    .rd_o({mem_chk_i, mem_dq_i})
  );

  // log masks and refreshes, cut hangs, hand write words on request
  always @(posedge clk_i)
  begin
    cyc++;
    if (mem_dq_oe_o)
      mq.push_back(memory_byte_mask_o);
    if (refresh_ack_o)
      refs++;
    if (cyc == 5000)
    begin
      fail_count++;
      print_verdict();
    end
    #2;
    if (wdata_req_o && wq.size() > 0)
      {be_i, wdata_i} = wq.pop_front();
  end

  task automatic print_verdict;
    if (fail_count == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : print_verdict

  task automatic tick;
    @(posedge clk_i);
    #2;
  endtask : tick

  task automatic chk(input string what, input logic [63:0] seen, exp);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // request stays up after the taking edge; the caller drops it
  task automatic req(input logic wr, input logic [ADDR_W-1:0] a,
                     input logic [LW+3:0] w);
    int n;
    if (wr)
      wq.push_back(w);
    write_req_i = wr;
    read_req_i = !wr;
    addr_i = a;
    for (n = 0; n < 300 && ready_o !== 1'b1; n++)
      tick();
    tick();
  endtask : req

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [LW-1:0] exp,
                    input logic err);
    int n;
    req(1'b0, a, '0);
    read_req_i = 1'b0;
    for (n = 0; n < 100 && rdata_valid_o !== 1'b1; n++)
      tick();
    chk("rdata", rdata_o, exp);
    chk("rdata_error", rdata_error_o, err);
  endtask : rd

  task automatic ecc_acc(input logic wr, input logic [1:0] a,
                         input logic [3:0] b, input logic [31:0] d);
    {ecc_write_req_i, ecc_read_req_i} = {wr, !wr};
    ecc_addr_i = a;
    correction_port_byte_en_i = b;
    ecc_wdata_i = d;
    tick();
    {ecc_write_req_i, ecc_read_req_i} = 2'h0;
    tick();
  endtask : ecc_acc

  task automatic pwr(input logic sr);
    int n;
    {self_rfsh_req_i, powerdn_req_i} = {sr, !sr};
    for (n = 0; n < 100 && (sr ? self_rfsh_ack_o : powerdn_ack_o) !== 1'b1;
         n++)
      tick();
    chk("power ack", sr ? self_rfsh_ack_o : powerdn_ack_o, 1'b1);
    {self_rfsh_req_i, powerdn_req_i} = 2'h0;
    repeat (2) tick();
    chk("power ack off", {self_rfsh_ack_o, powerdn_ack_o}, 2'h0);
  endtask : pwr

  // reset, early writes, reads with flips, side port, low power, reset
  initial
  begin
    {rst_n_i, pll_locked_i, seq_user_mode_rdy_i, resync_ok_i, postamble_ok_i,
     read_req_i, write_req_i, addr_i, wdata_i, be_i, powerdn_req_i, flip,
     self_rfsh_req_i, ecc_read_req_i, ecc_write_req_i, ecc_addr_i,
     correction_port_byte_en_i, ecc_wdata_i} = '0;
    repeat (3) tick();
    chk("ready in reset", ready_o, 1'b1);
    rst_n_i = 1'b1;
    repeat (4) tick();
    chk("reset request", reset_request_n_o, 1'b0);
    chk("user reset", user_rst_n_o, 1'b1);
    {pll_locked_i, resync_ok_i} = 2'h3;
    repeat (4) tick();
    chk("reset request", reset_request_n_o, 1'b1);
    chk("calibration", {resync_success_o, postamble_success_o}, 2'h2);
    chk("init done", init_done_o, 1'b0);
    for (i = 0; i < 4; i++)
      req(1'b1, 24'h001400 | 24'(i),
          {(i == 2) ? 4'h6 : 4'hf, 32'ha5c30f00 + 32'(i)});
    write_req_i = 1'b0;
    chk("ready full", ready_o, 1'b0);
    repeat (10) tick();
    chk("ready held", ready_o, 1'b0);
    seq_user_mode_rdy_i = 1'b1;
    repeat (2) tick();
    chk("init done", init_done_o, 1'b1);
    for (i = 0; i < 4; i++)
      rd(24'h001400 | 24'(i), 32'ha5c30f00 + 32'(i), 1'b0);
    chk("mask beats", mq.size(), 8);
    chk("masks", {mq[0], mq[1], mq[4], mq[5]}, 8'h06);
    flip = 2'h1;
    rd(24'h001400, 32'ha5c30f00, 1'b0);
    flip = 2'h3;
    rd(24'h001401, 32'ha5c30f01 ^ 32'h3, 1'b1);
    flip = 2'h0;
    ecc_acc(1'b0, ECC_REG_DBE, 4'hf, '0);
    chk("double count", ecc_rdata_o, 32'h1);
    ecc_acc(1'b1, ECC_REG_CTRL, 4'h1, 32'h1);
    chk("interrupt on", ecc_interrupt_o, 1'b1);
    ecc_acc(1'b1, ECC_REG_CTRL, 4'hf, 32'h0);
    chk("interrupt off", ecc_interrupt_o, 1'b0);
    chk("refresh seen", refs > 0, 1'b1);
    pwr(1'b0);
    pwr(1'b1);
    rst_n_i = 1'b0;
    tick();
    chk("reset outs", {init_done_o, user_rst_n_o, ready_o}, 3'h1);
    rst_n_i = 1'b1;
    repeat (3) tick();
    chk("init again", init_done_o, 1'b1);
    print_verdict();
  end

endmodule : tb_top
